// ==== hdl/fesp_pkg.sv ====
// Purpose: Constants for flash error flags and program-flash protection
// Assumes: 8-bit registers, one per aligned 32-bit AXI4-Lite word
// Notes:   Byte address of a register is four times its index
//
// How it works
// R1: Double fault or busy-block read sets double flag
// R2: Writing one clears double flag, zero keeps
// R3: Single fault or busy read sets single flag, unless ignore_single_fault is set
// R4: Writing one clears single flag, zero keeps
// R5: Reset loads protection from nonvolatile byte
// R6: Double fault on load gives full protection
// R7: Protected program or erase refused, violation set
// R8: Block erase refused if any sector protected
// R9: Mode bit selects protect or unprotect ranges
// R10: Mode and disables pick none, full, ranges
// R11: High disable bit governs range at top
// R12: High size selects 2, 4, 8, 16 KB
// R13: High size writable only while high disabled
// R14: Low disable bit governs range at base
// R15: Low size selects 1, 2, 4, 8 KB
// R16: Low size writable only while low disabled
// R17: Disallowed scenario writes ignored entirely
// R18: Scenario transitions follow the allowed table
// R19: Software leaves reserved nonvolatile bit erased
// R20: Flag with enable raises interrupt request
// R21: Scenario number is mode, high, low bits
// R22: Flag set beats same-cycle clear
package fesp_pkg;

    // ****************************************************
    // Register indices (byte address = index * 4)
    // ****************************************************
    localparam logic [3:0] FESP_IDX_CFG  = 4'h5;  // Enables and ignore bit
    localparam logic [3:0] FESP_IDX_STAT = 4'h6;  // Violation flag
    localparam logic [3:0] FESP_IDX_ERR  = 4'h7;  // flash_error_flags
    localparam logic [3:0] FESP_IDX_PROT = 4'h8;  // pflash_protect_config

    // ****************************************************
    // Field positions
    // ****************************************************
    localparam int FESP_ERR_SFD   = 0;  // single_fault_flag
    localparam int FESP_ERR_DFD   = 1;  // double_fault_flag
    localparam int FESP_CFG_SINGLE_FAULT_IRQ_ENABLE = 0;  // single_fault_irq_enable
    localparam int FESP_CFG_DOUBLE_FAULT_IRQ_ENABLE = 1;  // double_fault_irq_enable
    localparam int FESP_CFG_IGN   = 4;  // ignore_single_fault
    localparam int FESP_STAT_VIOL = 4;  // protect_violation_flag
    localparam int FESP_PR_MODE   = 7;  // protect_mode
    localparam int FESP_PR_RNV    = 6;  // reserved_nv_bit
    localparam int FESP_PR_HDIS   = 5;  // high_range_disable
    localparam int FESP_PR_HS     = 3;  // high_range_size low bit
    localparam int FESP_PR_LDIS   = 2;  // low_range_disable
    localparam int FESP_PR_LS     = 0;  // low_range_size low bit

    // ****************************************************
    // Reset values and addresses
    // ****************************************************
    localparam logic [7:0]  FESP_PROT_FULL  = 8'h7F;      // Mode clear, rest set
    localparam logic [7:0]  FESP_CFG_RST    = 8'h00;
    localparam logic [22:0] FESP_NV_ADDR    = 23'h7FFF0C;  // Protection byte
    localparam logic [22:0] FESP_PF_TOP     = 23'h7FFFFF;  // Top of program flash
    localparam logic [22:0] FESP_PF_LO_BASE = 23'h7F8000;  // Low range base
    localparam logic [22:0] FESP_HI_MIN     = 23'h000800;  // 2 KB
    localparam logic [22:0] FESP_LO_MIN     = 23'h000400;  // 1 KB

    // Allowed transitions: row is from-scenario, bit n allows to-scenario n
    localparam logic [7:0] FESP_ALLOWED [8] = '{
        8'h0F, 8'h0A, 8'h0C, 8'h08, 8'h18, 8'h3C, 8'h5A, 8'hFF};

    // AXI responses
    localparam logic [1:0] FESP_RESP_OK  = 2'h0;
    localparam logic [1:0] FESP_RESP_ERR = 2'h2;

    // Protection load sequencer, Gray along the path
    typedef enum logic [1:0] {
        FESP_LD_REQ  = 2'h0,
        FESP_LD_WAIT = 2'h1,
        FESP_RUN     = 2'h3
    } fesp_state_t;

endpackage

// ==== hdl/fesp_prot_decode.sv ====
// Purpose: Decides whether a program-flash address is protected
// Assumes: Program flash is one block ending at the top address
// Notes:   Purely combinational
`timescale 1ns/1ps
module fesp_prot_decode
    import fesp_pkg::*;
#(
    parameter logic [22:0] PF_BASE = 23'h7C0000  // Lowest program-flash address
) (
    input  wire logic [7:0]  i_cfg,       // pflash_protect_config
    input  wire logic [22:0] i_addr,      // Global address
    output logic             o_hit,       // Address protected
    output logic             o_any_prot   // Some sector of the block protected
);
    logic [22:0] hi_size;  // High range byte count
    logic [22:0] lo_size;  // Low range byte count
    logic        in_hi;    // Address inside high range
    logic        in_lo;    // Address inside low range
    logic        ranged;   // Address in an active range

    // ****************************************************
    // Range decode
    // ****************************************************
    always_comb begin
        hi_size = FESP_HI_MIN << i_cfg[FESP_PR_HS +: 2];  // see R12
        lo_size = FESP_LO_MIN << i_cfg[FESP_PR_LS +: 2];  // see R15
        in_hi   = i_addr > (FESP_PF_TOP - hi_size);        // see R11
        in_lo   = (i_addr >= FESP_PF_LO_BASE) &&
                  (i_addr < FESP_PF_LO_BASE + lo_size);    // see R14
        ranged  = (in_hi && !i_cfg[FESP_PR_HDIS]) || (in_lo && !i_cfg[FESP_PR_LDIS]);
        // Mode set protects ranges, clear protects all else; see R9 R10
        if (i_addr < PF_BASE) begin
            o_hit = 1'b0;  // Not program flash
        end else if (i_cfg[FESP_PR_MODE]) begin
            o_hit = ranged;
        end else begin
            o_hit = !ranged;
        end
        // Ranges never cover the block, so only scenario 7 is open; see R8 R21
        o_any_prot = !(i_cfg[FESP_PR_MODE] && i_cfg[FESP_PR_HDIS] && i_cfg[FESP_PR_LDIS]);
    end

endmodule

// ==== hdl/fesp_top.sv ====
// Purpose: Flash error flags and program-flash protection register
// Assumes: Flash-side inputs come from logic on I_CLK_SYS
// Notes:   Registers over AXI4-Lite; protection loaded after reset
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
module fesp_top
    import fesp_pkg::*;
#(
    parameter int          ADDR_W  = 12,         // AXI address width
    parameter logic [22:0] PF_BASE = 23'h7C0000  // Lowest program-flash address
) (
    input  wire logic              I_CLK_SYS,         // 40 MHz clock
    input  wire logic              I_RST,             // Async reset, high
    // AXI4-Lite slave
    input  wire logic              I_AXI_AWVALID,
    output logic                   O_AXI_AWREADY,
    input  wire logic [ADDR_W-1:0] I_AXI_AWADDR,
    input  wire logic              I_AXI_WVALID,
    output logic                   O_AXI_WREADY,
    input  wire logic [31:0]       I_AXI_WDATA,
    input  wire logic [3:0]        I_AXI_WSTRB,
    output logic                   O_AXI_BVALID,
    input  wire logic              I_AXI_BREADY,
    output logic [1:0]             O_AXI_BRESP,
    input  wire logic              I_AXI_ARVALID,
    output logic                   O_AXI_ARREADY,
    input  wire logic [ADDR_W-1:0] I_AXI_ARADDR,
    output logic                   O_AXI_RVALID,
    input  wire logic              I_AXI_RREADY,
    output logic [31:0]            O_AXI_RDATA,
    output logic [1:0]             O_AXI_RRESP,
    // Array read results
    input  wire logic              I_RD_DONE,         // Array read finished
    input  wire logic              I_RD_SGL,          // One-bit error corrected
    input  wire logic              I_RD_DBL,          // Two-bit error found
    input  wire logic              I_RD_BUSY,         // Read hit a busy block
    // Protection byte fetch at reset
    output logic                   O_NV_RD_REQ,       // Fetch pulse
    output logic [22:0]            O_NV_RD_ADDR,      // Fetch address
    input  wire logic              I_NV_RD_VALID,     // Fetch answered
    input  wire logic [7:0]        I_NV_RD_DATA,      // Protection byte
    input  wire logic              I_NV_RD_DBL,       // Two-bit error on fetch
    output logic                   O_READY,           // Protection loaded
    // Program and erase check
    input  wire logic              I_PE_REQ,          // Check pulse
    input  wire logic [22:0]       I_PE_ADDR,         // Target address
    input  wire logic              I_PE_BLK_ERASE,    // Block erase command
    output logic                   O_PE_GRANT,        // Allowed pulse
    output logic                   O_PE_DENY,         // Refused pulse
    // Interrupt requests
    output logic                   O_IRQ_DFD,         // Double fault request
    output logic                   O_IRQ_SFD          // Single fault request
);
    // Decode needs address bits 5:2, and the bus is 32 bits at most
    if (ADDR_W < 6 || ADDR_W > 32) begin : g_addr_w_check
        $error("ADDR_W out of range");
    end

    // ****************************************************
    // State
    // ****************************************************
    fesp_state_t       state_q;      // Load sequencer
    logic [7:0]        prot_q;       // pflash_protect_config
    logic [7:0]        cfg_q;        // Enables and ignore bit
    logic              dfd_q;        // double_fault_flag
    logic              sfd_q;        // single_fault_flag
    logic              viol_q;       // protect_violation_flag
    logic              aw_hold_q;    // Write address held
    logic              w_hold_q;     // Write data held
    logic [ADDR_W-1:0] aw_addr_q;
    logic [7:0]        w_data_q;
    logic              w_lane_q;     // Byte lane 0 enabled
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [31:0]       rdata_q;
    logic [1:0]        rresp_q;
    logic              nv_req_q;
    logic              grant_q;
    logic              deny_q;

    // ****************************************************
    // Bus decode
    // ****************************************************
    logic       do_wr;       // Write executes this cycle
    logic [3:0] wr_idx;
    logic       wr_map;      // Write hits a register
    logic       wr_err;
    logic       wr_stat;
    logic       wr_prot;
    logic       wr_cfg;
    logic [3:0] rd_idx;
    logic       rd_map;
    logic [7:0] rd_byte;

    // Index from address; upper bits must be zero
    function automatic logic [4:0] fesp_dec(input logic [ADDR_W-1:0] a);
        logic [3:0] idx;
        logic       ok;
        idx = a[5:2];
        ok  = (a >> 6) == '0;
        ok  = ok && (idx == FESP_IDX_CFG || idx == FESP_IDX_STAT ||
                     idx == FESP_IDX_ERR || idx == FESP_IDX_PROT);
        return {ok, idx};
    endfunction

    assign O_AXI_AWREADY = !aw_hold_q && !bvalid_q;
    assign O_AXI_WREADY  = !w_hold_q && !bvalid_q;
    assign O_AXI_ARREADY = !rvalid_q;
    assign do_wr         = aw_hold_q && w_hold_q && !bvalid_q;
    assign {wr_map, wr_idx} = fesp_dec(aw_addr_q);
    assign {rd_map, rd_idx} = fesp_dec(I_AXI_ARADDR);
    assign wr_err  = do_wr && wr_map && w_lane_q && wr_idx == FESP_IDX_ERR;
    assign wr_stat = do_wr && wr_map && w_lane_q && wr_idx == FESP_IDX_STAT;
    assign wr_cfg  = do_wr && wr_map && w_lane_q && wr_idx == FESP_IDX_CFG;
    assign wr_prot = do_wr && wr_map && w_lane_q && wr_idx == FESP_IDX_PROT;

    // Read data mux; unused bits read zero
    always_comb begin
        case (rd_idx)
            FESP_IDX_CFG:  rd_byte = cfg_q;
            FESP_IDX_STAT: rd_byte = 8'(viol_q) << FESP_STAT_VIOL;
            FESP_IDX_ERR:  rd_byte = (8'(dfd_q) << FESP_ERR_DFD) | (8'(sfd_q) << FESP_ERR_SFD);
            FESP_IDX_PROT: rd_byte = prot_q;
            default:       rd_byte = 8'h00;
        endcase
    end

    // Write channel capture; address and data in either order
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= 8'h00;
            w_lane_q  <= 1'b0;
        end else if (do_wr) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
        end else begin
            if (I_AXI_AWVALID && O_AXI_AWREADY) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= I_AXI_AWADDR;
            end
            if (I_AXI_WVALID && O_AXI_WREADY) begin
                w_hold_q <= 1'b1;
                w_data_q <= I_AXI_WDATA[7:0];
                w_lane_q <= I_AXI_WSTRB[0];
            end
        end
    end

    // Write response; unmapped addresses answer SLVERR
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            bvalid_q <= 1'b0;
            bresp_q  <= FESP_RESP_OK;
        end else if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_map ? FESP_RESP_OK : FESP_RESP_ERR;
        end else if (I_AXI_BREADY) begin
            bvalid_q <= 1'b0;
        end
    end

    // Read channel; one read in flight
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= FESP_RESP_OK;
        end else if (I_AXI_ARVALID && O_AXI_ARREADY) begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h000000, rd_byte};
            rresp_q  <= rd_map ? FESP_RESP_OK : FESP_RESP_ERR;
        end else if (I_AXI_RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

    assign O_AXI_BVALID = bvalid_q;
    assign O_AXI_BRESP  = bresp_q;
    assign O_AXI_RVALID = rvalid_q;
    assign O_AXI_RDATA  = rdata_q;
    assign O_AXI_RRESP  = rresp_q;

    // ****************************************************
    // Error flags
    // ****************************************************
    logic dfd_set;  // Double flag event
    logic sfd_set;  // Single flag event

    assign dfd_set = I_RD_DONE && (I_RD_DBL || I_RD_BUSY);                          // see R1
    assign sfd_set = I_RD_DONE && !cfg_q[FESP_CFG_IGN] && (I_RD_SGL || I_RD_BUSY);  // see R3

    // Write-one-to-clear, set wins so no event is lost
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            dfd_q <= 1'b0;
            sfd_q <= 1'b0;
        end else begin
            dfd_q <= dfd_set || (dfd_q && !(wr_err && w_data_q[FESP_ERR_DFD]));  // see R2 R22
            sfd_q <= sfd_set || (sfd_q && !(wr_err && w_data_q[FESP_ERR_SFD]));  // see R4 R22
        end
    end

    // Configuration: plain read/write
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            cfg_q <= FESP_CFG_RST;
        end else if (wr_cfg) begin
            cfg_q <= w_data_q & 8'h13;  // Only implemented bits
        end
    end

    // Interrupt requests from flag and enable
    assign O_IRQ_DFD = dfd_q && cfg_q[FESP_CFG_DOUBLE_FAULT_IRQ_ENABLE];  // see R20
    assign O_IRQ_SFD = sfd_q && cfg_q[FESP_CFG_SINGLE_FAULT_IRQ_ENABLE];  // see R20

    // ****************************************************
    // Protection load at reset
    // ****************************************************
    // Register starts fully protected so nothing slips through before load
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            state_q  <= FESP_LD_REQ;
            nv_req_q <= 1'b0;
        end else begin
            nv_req_q <= 1'b0;
            case (state_q)
                FESP_LD_REQ: begin
                    nv_req_q <= 1'b1;  // see R5
                    state_q  <= FESP_LD_WAIT;
                end
                FESP_LD_WAIT: begin
                    if (I_NV_RD_VALID) begin
                        state_q <= FESP_RUN;
                    end
                end
                FESP_RUN: begin
                    state_q <= FESP_RUN;
                end
                default: begin
                    state_q <= FESP_LD_REQ;
                end
            endcase
        end
    end

    assign O_NV_RD_REQ  = nv_req_q;
    assign O_NV_RD_ADDR = FESP_NV_ADDR;  // see R5
    assign O_READY      = state_q == FESP_RUN;

    // ****************************************************
    // Protection register
    // ****************************************************
    logic [7:0] prot_cand;  // Requested value after size locks
    logic [2:0] sc_cur;     // Current scenario
    logic [2:0] sc_new;     // Requested scenario
    logic       sc_ok;      // Transition allowed

    always_comb begin
        prot_cand = w_data_q;
        prot_cand[FESP_PR_RNV] = prot_q[FESP_PR_RNV];  // Reserved bit kept from load
        if (!prot_q[FESP_PR_HDIS]) begin
            prot_cand[FESP_PR_HS +: 2] = prot_q[FESP_PR_HS +: 2];  // see R13
        end
        if (!prot_q[FESP_PR_LDIS]) begin
            prot_cand[FESP_PR_LS +: 2] = prot_q[FESP_PR_LS +: 2];  // see R16
        end
        sc_cur = {prot_q[FESP_PR_MODE], prot_q[FESP_PR_HDIS], prot_q[FESP_PR_LDIS]};  // see R21
        sc_new = {prot_cand[FESP_PR_MODE], prot_cand[FESP_PR_HDIS], prot_cand[FESP_PR_LDIS]};
        sc_ok  = FESP_ALLOWED[sc_cur][sc_new];  // see R18
    end

    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            prot_q <= FESP_PROT_FULL;
        end else if (state_q == FESP_LD_WAIT && I_NV_RD_VALID) begin
            prot_q <= I_NV_RD_DBL ? FESP_PROT_FULL : I_NV_RD_DATA;  // see R5 R6
        end else if (wr_prot && state_q == FESP_RUN && sc_ok) begin
            prot_q <= prot_cand;  // see R17
        end
    end

    // ****************************************************
    // Program and erase check
    // ****************************************************
    logic pe_hit;  // Target address protected
    logic pe_any;  // Block has protection
    logic pe_bad;  // Request refused

    fesp_prot_decode #(
        .PF_BASE    (PF_BASE)
    ) u_decode (
        .i_cfg      (prot_q),
        .i_addr     (I_PE_ADDR),
        .o_hit      (pe_hit),
        .o_any_prot (pe_any)
    );

    assign pe_bad = pe_hit || (I_PE_BLK_ERASE && pe_any && I_PE_ADDR >= PF_BASE);  // see R7 R8

    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            grant_q <= 1'b0;
            deny_q  <= 1'b0;
        end else begin
            grant_q <= I_PE_REQ && !pe_bad;
            deny_q  <= I_PE_REQ && pe_bad;  // see R7
        end
    end

    // Violation flag, write-one-to-clear, set wins
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            viol_q <= 1'b0;
        end else begin
            viol_q <= (I_PE_REQ && pe_bad) || (viol_q && !(wr_stat && w_data_q[FESP_STAT_VIOL]));  // see R7 R22
        end
    end

    assign O_PE_GRANT = grant_q;
    assign O_PE_DENY  = deny_q;

    // ****************************************************
    // Assertions
    // ****************************************************
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RST);

    a_dfd_on_event:  assert property (dfd_set |=> dfd_q)  // see R1
        else $error("double flag not set");
    a_dfd_w1c:       assert property (wr_err && w_data_q[1] && !dfd_set |=> !dfd_q)  // see R2
        else $error("double flag not cleared");
    a_sfd_ignored:   assert property ($rose(sfd_q) |-> !$past(cfg_q[4]) && $past(I_RD_DONE))  // see R3
        else $error("single flag set while ignored");
    a_sfd_keep:      assert property (sfd_q && !(wr_err && w_data_q[0]) |=> sfd_q)  // see R4
        else $error("single flag lost");
    a_load_byte:     assert property (state_q == FESP_LD_WAIT && I_NV_RD_VALID && !I_NV_RD_DBL
                                      |=> prot_q == $past(I_NV_RD_DATA) && O_READY)  // see R5
        else $error("protection byte not loaded");
    a_load_dbl:      assert property (state_q == FESP_LD_WAIT && I_NV_RD_VALID && I_NV_RD_DBL
                                      |=> prot_q == 8'h7F)  // see R6
        else $error("double fault load not fully protected");
    a_deny_viol:     assert property (I_PE_REQ && pe_hit |=> O_PE_DENY && !O_PE_GRANT && viol_q)  // see R7
        else $error("protected target not refused");
    a_blk_erase:     assert property (I_PE_REQ && I_PE_BLK_ERASE && pe_any && I_PE_ADDR >= PF_BASE
                                      |=> O_PE_DENY)  // see R8
        else $error("block erase not refused");
    a_prot_hold:     assert property (O_READY && !sc_ok |=> $stable(prot_q))  // see R17
        else $error("disallowed scenario written");
    a_hsize_lock:    assert property (O_READY && !prot_q[5] |=> $stable(prot_q[4:3]))  // see R13
        else $error("high size changed while active");
    a_irq_dfd:       assert property (dfd_q && cfg_q[1] |-> O_IRQ_DFD)  // see R20
        else $error("double irq missing");

    c_dfd_set:   cover property (dfd_set ##1 wr_err ##1 !dfd_q);
    c_prot_wr:   cover property (wr_prot && sc_ok && sc_cur != sc_new);
    c_pe_deny:   cover property (I_PE_REQ && pe_bad ##1 O_PE_DENY);
    c_load_dbl:  cover property (state_q == FESP_LD_WAIT && I_NV_RD_VALID && I_NV_RD_DBL);

endmodule

// ==== verification/fesp_flash_model.sv ====
// Purpose: Flash array side that answers the protection byte fetch
// Assumes: One fetch per reset, byte chosen by the bench
// Notes:   Released data bus shows the inverse of the byte
`timescale 1ns/1ps
module fesp_flash_model (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_req,   // Fetch pulse
    input  wire logic [7:0] i_byte,  // Stored byte, bit6 erased
    input  wire logic       i_dbl,   // Inject two-bit fault
    output logic            o_valid,
    output logic [7:0]      o_data,
    output logic            o_dbl
);
    logic [2:0] cnt_q;  // Slow answer, four cycles
    // Answer timer
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q   <= 3'h0;
            o_valid <= 1'b0;
        end else begin
            if (i_req) cnt_q <= 3'h4;
            else if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
            o_valid <= (cnt_q == 3'h1);
        end
    end
    // Idle bus never repeats the byte, so a late sample is caught
    assign o_data = o_valid ? i_byte : ~i_byte;
    assign o_dbl  = o_valid & i_dbl;
endmodule

// ==== verification/test_fesp_top.sv ====
// Purpose: Bench for flash error flags and protection register
// Assumes: Default parameters, 40 MHz clock
// Notes:   Expected values worked out by hand from the rules
`timescale 1ns/1ps
module test_fesp_top;
    logic I_CLK_SYS, I_RST, I_AXI_AWVALID, I_AXI_WVALID, I_AXI_BREADY, I_AXI_ARVALID, I_AXI_RREADY;
    logic I_RD_DONE, I_RD_SGL, I_RD_DBL, I_RD_BUSY, I_NV_RD_VALID, I_NV_RD_DBL, I_PE_REQ, I_PE_BLK_ERASE;
    logic O_AXI_AWREADY, O_AXI_WREADY, O_AXI_BVALID, O_AXI_ARREADY, O_AXI_RVALID, O_NV_RD_REQ;
    logic O_READY, O_PE_GRANT, O_PE_DENY, O_IRQ_DFD, O_IRQ_SFD, nv_dbl;
    logic [11:0] I_AXI_AWADDR, I_AXI_ARADDR;
    logic [31:0] I_AXI_WDATA, O_AXI_RDATA;
    logic [3:0]  I_AXI_WSTRB;
    logic [1:0]  O_AXI_BRESP, O_AXI_RRESP;
    logic [7:0]  I_NV_RD_DATA, nv_byte;
    logic [22:0] O_NV_RD_ADDR, I_PE_ADDR;
    int          n_mismatch, compares;
    fesp_top u_dut (.*);
    fesp_flash_model u_flash (.i_clk(I_CLK_SYS), .i_rst(I_RST), .i_req(O_NV_RD_REQ), .i_byte(nv_byte),
        .i_dbl(nv_dbl), .o_valid(I_NV_RD_VALID), .o_data(I_NV_RD_DATA), .o_dbl(I_NV_RD_DBL));
    initial begin
        I_CLK_SYS = 1'b0;
        forever #12.5 I_CLK_SYS = ~I_CLK_SYS;
    end
    task automatic chk(input string n, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    // AXI write, both channels offered together, response compared
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
        @(posedge I_CLK_SYS);
        {I_AXI_AWVALID, I_AXI_WVALID, I_AXI_BREADY} <= 3'h7;
        I_AXI_AWADDR <= a;
        I_AXI_WDATA  <= {24'h0, d};
        do begin
            @(posedge I_CLK_SYS);
            if (O_AXI_AWREADY) I_AXI_AWVALID <= 1'b0;
            if (O_AXI_WREADY) I_AXI_WVALID <= 1'b0;
        end while (!O_AXI_BVALID);
        I_AXI_BREADY <= 1'b0;
        chk("write resp", {30'h0, r}, {30'h0, O_AXI_BRESP});
    endtask
    // AXI read with data and response compare
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
        @(posedge I_CLK_SYS);
        {I_AXI_ARVALID, I_AXI_RREADY} <= 2'h3;
        I_AXI_ARADDR <= a;
        do begin
            @(posedge I_CLK_SYS);
            if (O_AXI_ARREADY) I_AXI_ARVALID <= 1'b0;
        end while (!O_AXI_RVALID);
        I_AXI_RREADY <= 1'b0;
        chk("read data", e, O_AXI_RDATA);
        chk("read resp", {30'h0, r}, {30'h0, O_AXI_RRESP});
    endtask
    // One array read result
    task automatic ev(input logic s, d, b);
        @(posedge I_CLK_SYS);
        {I_RD_DONE, I_RD_SGL, I_RD_DBL, I_RD_BUSY} <= {1'b1, s, d, b};
        @(posedge I_CLK_SYS);
        I_RD_DONE <= 1'b0;
    endtask
    // Program or erase check, answer one cycle after it is taken
    task automatic pe(input logic [22:0] a, input logic blk, dny);
        @(posedge I_CLK_SYS);
        {I_PE_REQ, I_PE_ADDR, I_PE_BLK_ERASE} <= {1'b1, a, blk};
        @(posedge I_CLK_SYS);
        I_PE_REQ <= 1'b0;
        @(posedge I_CLK_SYS);
        chk("deny grant", {30'h0, dny, !dny}, {30'h0, O_PE_DENY, O_PE_GRANT});
    endtask
    task automatic boot(input logic dbl);
        @(posedge I_CLK_SYS);
        {I_RST, nv_dbl} <= {1'b1, dbl};
        repeat (6) @(posedge I_CLK_SYS);
        I_RST <= 1'b0;
        while (!O_READY) @(posedge I_CLK_SYS);
    endtask
    task automatic summarize;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge I_CLK_SYS);
        n_mismatch++;
        summarize();
    end
    initial begin
        {I_AXI_AWVALID, I_AXI_WVALID, I_AXI_BREADY, I_AXI_ARVALID, I_AXI_RREADY, I_AXI_AWADDR} = '0;
        {I_RD_DONE, I_RD_SGL, I_RD_DBL, I_RD_BUSY, I_PE_REQ, I_PE_BLK_ERASE, I_PE_ADDR} = '0;
        {I_AXI_ARADDR, I_AXI_WDATA, n_mismatch, compares} = '0;
        {I_RST, I_AXI_WSTRB, nv_byte, nv_dbl} = {1'b1, 4'hF, 8'hFF, 1'b0};
        boot(1'b0);
        chk("fetch addr", 32'h7FFF0C, {9'h0, O_NV_RD_ADDR});
        rd(12'h020, 32'hFF, 2'h0);
        rd(12'h03C, 32'h0, 2'h2);
        wr(12'h03C, 8'hFF, 2'h2);
        pe(23'h7FFFFF, 1'b0, 1'b0);
        pe(23'h7C0000, 1'b1, 1'b0);
        wr(12'h014, 8'h03);
        I_AXI_WSTRB <= 4'hE;
        wr(12'h014, 8'h00);
        I_AXI_WSTRB <= 4'hF;
        ev(1'b0, 1'b1, 1'b0);
        rd(12'h01C, 32'h2, 2'h0);
        chk("irq", 32'h2, {30'h0, O_IRQ_DFD, O_IRQ_SFD});
        wr(12'h01C, 8'h00);
        rd(12'h01C, 32'h2, 2'h0);
        wr(12'h01C, 8'h02);
        rd(12'h01C, 32'h0, 2'h0);
        ev(1'b1, 1'b0, 1'b0);
        rd(12'h01C, 32'h1, 2'h0);
        chk("irq", 32'h1, {30'h0, O_IRQ_DFD, O_IRQ_SFD});
        wr(12'h01C, 8'h01);
        rd(12'h01C, 32'h0, 2'h0);
        ev(1'b0, 1'b0, 1'b1);
        rd(12'h01C, 32'h3, 2'h0);
        wr(12'h01C, 8'h03);
        wr(12'h014, 8'h13);
        ev(1'b1, 1'b0, 1'b1);
        rd(12'h01C, 32'h2, 2'h0);
        wr(12'h020, 8'h97);
        rd(12'h020, 32'hD7, 2'h0);
        pe(23'h7FE000, 1'b0, 1'b1);
        pe(23'h7FDFFF, 1'b0, 1'b0);
        rd(12'h018, 32'h10, 2'h0);
        wr(12'h020, 8'hFF);
        rd(12'h020, 32'hD7, 2'h0);
        wr(12'h020, 8'h83);
        rd(12'h020, 32'hD3, 2'h0);
        pe(23'h7F9FFF, 1'b0, 1'b1);
        pe(23'h7FA000, 1'b0, 1'b0);
        pe(23'h7C0000, 1'b1, 1'b1);
        boot(1'b1);
        rd(12'h020, 32'h7F, 2'h0);
        pe(23'h7C0000, 1'b0, 1'b1);
        summarize();
    end
endmodule
